// ==== hdl/ppog_duty_div.sv ====
`default_nettype none
module ppog_duty_div (
   input wire logic clk, // 200 MHz clock
   input wire logic rst_n, // Async reset, active low
   input wire logic [15:0] command, // Signed command
   input wire logic [15:0] scale, // Unsigned scale factor
   output logic [9:0] dutyMag, // Clipped magnitude, full = 512
   output logic dutyNeg // Command was negative
);
   logic busy;
   logic [3:0] step;
   logic [15:0] rem;
   logic [15:0] capScale;
   logic capNeg;
   logic [8:0] quo;
   wire [15:0] absCmd = command[15] ? 16'(-command) : command;
   wire [16:0] trial = {rem, 1'b0};
   wire fits = trial >= {1'b0, capScale};
   wire [15:0] next_rem = fits ? 16'(trial - {1'b0, capScale}) : trial[15:0];
   wire [8:0] next_quo = {quo[7:0], fits};
   wire clips = absCmd >= scale;

   // Free-running recompute; a change may wait out a run already in flight,
   // so it can take up to 2*DUTY_BITS+1 cycles to show
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
         step <= 4'h0;
         rem <= 16'h0000;
         capScale <= 16'h0000;
         capNeg <= 1'b0;
         quo <= 9'h000;
         dutyMag <= 10'h000;
         dutyNeg <= 1'b0;
      end else if (!busy) begin
         capNeg <= command[15];
         capScale <= scale;
         rem <= absCmd;
         quo <= 9'h000;
         step <= 4'(ppog_pkg::DUTY_BITS);
         if (absCmd == 16'h0000) begin
            dutyMag <= 10'h000;
            dutyNeg <= 1'b0;
         end else if (clips) begin
            dutyMag <= ppog_pkg::DUTY_FULL;
            dutyNeg <= command[15];
         end else begin
            busy <= 1'b1;
         end
      end else begin
         rem <= next_rem;
         quo <= next_quo;
         step <= step - 4'h1;
         if (step == 4'h1) begin
            busy <= 1'b0;
            dutyMag <= {1'b0, next_quo};
            dutyNeg <= capNeg;
         end
      end
   end
endmodule : ppog_duty_div
`default_nettype wire

// ==== hdl/ppog_pkg.sv ====
`default_nettype none
package ppog_pkg;
   localparam int CLK_HZ = 200_000_000;
   localparam int DUTY_BITS = 9;
   localparam int NUM_PINS = 3;
   localparam logic [9:0] DUTY_FULL = 10'h200;
   // Increment = Hz * 2^32 / CLK_HZ, done as Hz * INC_MUL >> INC_SHIFT
   localparam int INC_SHIFT = 8;
   localparam logic [13:0] INC_MUL = 14'((64'h1 << 40) / CLK_HZ);
   localparam logic [31:0] PWM_MIN_HZ = 32'h1;
   localparam logic [31:0] PWM_MAX_HZ = 32'(CLK_HZ >> DUTY_BITS);
   localparam logic [31:0] PDM_MIN_HZ = 32'(CLK_HZ >> 16);
   localparam logic [31:0] PDM_MAX_HZ = 32'(CLK_HZ - 1);
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_COMMAND = 8'h04;
   localparam logic [7:0] OFS_SCALE = 8'h08;
   localparam logic [7:0] OFS_PWM_HZ = 8'h0c;
   localparam logic [7:0] OFS_PDM_HZ = 8'h10;
   localparam logic [7:0] OFS_PIN_CFG = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_FMT_LSB = 4;
   localparam int PIN_CFG_STRIDE = 4;
   localparam int STAT_NEG_BIT = 4;
   localparam int STAT_MAG_LSB = 16;
   localparam int PIN_NEN = 0;
   localparam int PIN_FIRST = 1;
   localparam int PIN_SECOND = 2;
   localparam logic [2:0] RST_FORMAT = 3'h1;
   localparam logic [15:0] RST_COMMAND = 16'h0000;
   localparam logic [15:0] RST_SCALE = 16'h0001;
   localparam logic [31:0] RST_PWM_HZ = 32'h00004e20;
   localparam logic [31:0] RST_PDM_HZ = 32'h000f4240;
   typedef enum logic [2:0] {
      FMT_OFF = 3'b000,
      FMT_PWM_DIR = 3'b001,
      FMT_UP_DOWN = 3'b010,
      FMT_PDM_DIR = 3'b011,
      FMT_DIR_PWM = 3'b100
   } ppog_fmt_t;
   typedef struct packed {
      logic flip;
      logic pinDrainOnly;
      logic pinDriveDirection;
   } ppog_pin_cfg_t;
   typedef struct packed {
      logic [NUM_PINS-1:0] out;
      logic [NUM_PINS-1:0] oe;
   } ppog_pins_t;
endpackage : ppog_pkg
`default_nettype wire

// ==== hdl/ppog_top.sv ====
// Implementation choices: the register addresses and register access over Wishbone.
`default_nettype none
module ppog_top (
   input wire logic clk, // 200 MHz clock
   input wire logic rst_n, // Async reset, active low
   input wire logic wb_cyc_i, // Wishbone cycle
   input wire logic wb_stb_i, // Wishbone strobe
   input wire logic wb_we_i, // Wishbone write
   input wire logic [7:0] wb_adr_i, // Byte address
   input wire logic [3:0] wb_sel_i, // Byte lanes
   input wire logic [31:0] wb_dat_i, // Write data
   output logic [31:0] wb_dat_o, // Read data
   output logic wb_ack_o, // Acknowledge
   input wire logic [2:0] pinSense, // Pin levels, asynchronous
   output var ppog_pkg::ppog_pins_t pinDrive // Pin drive and enables
);
   logic enable;
   logic [2:0] format;
   logic [15:0] command;
   logic [15:0] scale;
   logic [31:0] pwmHz;
   logic [31:0] pdmHz;
   ppog_pkg::ppog_pin_cfg_t pinCfg [ppog_pkg::NUM_PINS];
   logic [2:0] senseMeta;
   logic [2:0] senseSync;

   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wrStb = req & wb_we_i;
   wire [5:0] word = wb_adr_i[7:2];
   wire hitCtrl = word == ppog_pkg::OFS_CTRL[7:2];
   wire hitCmd = word == ppog_pkg::OFS_COMMAND[7:2];
   wire hitScale = word == ppog_pkg::OFS_SCALE[7:2];
   wire hitPwm = word == ppog_pkg::OFS_PWM_HZ[7:2];
   wire hitPdm = word == ppog_pkg::OFS_PDM_HZ[7:2];
   wire hitPin = word == ppog_pkg::OFS_PIN_CFG[7:2];
   wire hitStat = word == ppog_pkg::OFS_STATUS[7:2];
   wire [31:0] wMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] dat,
                                         input logic [31:0] mask);
      merge = (old & ~mask) | (dat & mask);
   endfunction : merge

   function automatic logic [31:0] clip(input logic [31:0] v,
                                        input logic [31:0] lo,
                                        input logic [31:0] hi);
      clip = (v > hi) ? hi : ((v < lo) ? lo : v);
   endfunction : clip

   logic [9:0] dutyMag;
   logic dutyNeg;
   wire [9:0] magClip = (dutyMag > ppog_pkg::DUTY_FULL) ?
                        ppog_pkg::DUTY_FULL : dutyMag;
   logic [31:0] pinView;
   logic [31:0] statView;
   always_comb begin
      pinView = 32'h0;
      statView = 32'h0;
      for (int i = 0; i < ppog_pkg::NUM_PINS; i++) begin
         pinView[i*ppog_pkg::PIN_CFG_STRIDE +: 3] = pinCfg[i];
      end
      statView[2:0] = senseSync;
      statView[ppog_pkg::STAT_NEG_BIT] = dutyNeg;
      statView[ppog_pkg::STAT_MAG_LSB +: 10] = magClip;
   end

   wire [31:0] ctrlView = {25'h0, format, 3'h0, enable};
   wire [31:0] ctrlNew = merge(ctrlView, wb_dat_i, wMask);
   wire [31:0] cmdNew = merge({16'h0, command}, wb_dat_i, wMask);
   wire [31:0] sclNew = merge({16'h0, scale}, wb_dat_i, wMask);
   wire [31:0] pwmRaw = merge(pwmHz, wb_dat_i, wMask);
   wire [31:0] pdmRaw = merge(pdmHz, wb_dat_i, wMask);
   wire [31:0] pinNew = merge(pinView, wb_dat_i, wMask);
   wire [31:0] rdMux = hitCtrl ? ctrlView :
                       hitCmd ? {16'h0, command} :
                       hitScale ? {16'h0, scale} :
                       hitPwm ? pwmHz :
                       hitPdm ? pdmHz :
                       hitPin ? pinView :
                       hitStat ? statView : 32'h0;

   // Every address acks; unmapped reads give zero and writes are dropped
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= req;
         if (req) begin
            wb_dat_o <= rdMux;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         enable <= 1'b0;
         format <= ppog_pkg::RST_FORMAT;
         command <= ppog_pkg::RST_COMMAND;
         scale <= ppog_pkg::RST_SCALE;
      end else if (wrStb) begin
         if (hitCtrl) begin
            enable <= ctrlNew[ppog_pkg::CTRL_EN_BIT];
            format <= ctrlNew[ppog_pkg::CTRL_FMT_LSB +: 3];
         end
         if (hitCmd) begin
            command <= cmdNew[15:0];
         end
         if (hitScale) begin
            scale <= sclNew[15:0];
         end
      end
   end

   // Clipped at write time so a read shows the rate really in use
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwmHz <= ppog_pkg::RST_PWM_HZ;
         pdmHz <= ppog_pkg::RST_PDM_HZ;
      end else if (wrStb) begin
         if (hitPwm) begin
            pwmHz <= clip(pwmRaw, ppog_pkg::PWM_MIN_HZ,
                          ppog_pkg::PWM_MAX_HZ);
         end
         if (hitPdm) begin
            pdmHz <= clip(pdmRaw, ppog_pkg::PDM_MIN_HZ,
                          ppog_pkg::PDM_MAX_HZ);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         senseMeta <= 3'h7;
         senseSync <= 3'h7;
      end else begin
         senseMeta <= pinSense;
         senseSync <= senseMeta;
      end
   end

   ppog_duty_div uDiv (
      .clk(clk),
      .rst_n(rst_n),
      .command(command),
      .scale(scale),
      .dutyMag(dutyMag),
      .dutyNeg(dutyNeg)
   );

   // Phase accumulators; both rates are shared by every format using them
   logic [31:0] pwmInc;
   logic [31:0] pdmInc;
   logic [31:0] pwmPhase;
   logic [31:0] pdmPhase;
   logic pdmTick;
   logic [9:0] sigma;
   logic pdmPulse;
   wire [45:0] pwmProd = pwmHz * ppog_pkg::INC_MUL;
   wire [45:0] pdmProd = pdmHz * ppog_pkg::INC_MUL;
   wire [32:0] pdmSum = {1'b0, pdmPhase} + {1'b0, pdmInc};
   wire [8:0] ramp = pwmPhase[31:23];
   wire pwmPulse = {1'b0, ramp} < magClip;
   wire [10:0] sigmaSum = {1'b0, sigma} + {1'b0, magClip};
   wire slotHit = sigmaSum >= {1'b0, ppog_pkg::DUTY_FULL};
   wire [10:0] sigmaLeft = slotHit ?
                           11'(sigmaSum - {1'b0, ppog_pkg::DUTY_FULL}) :
                           sigmaSum;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwmInc <= 32'h0;
         pdmInc <= 32'h0;
         pwmPhase <= 32'h0;
         pdmPhase <= 32'h0;
         pdmTick <= 1'b0;
      end else begin
         pwmInc <= pwmProd[ppog_pkg::INC_SHIFT +: 32];
         pdmInc <= pdmProd[ppog_pkg::INC_SHIFT +: 32];
         pwmPhase <= pwmPhase + pwmInc;
         pdmPhase <= pdmSum[31:0];
         pdmTick <= pdmSum[32];
      end
   end

   // Error feedback: pulse density over slots equals the magnitude
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sigma <= 10'h000;
         pdmPulse <= 1'b0;
      end else if (pdmTick) begin
         sigma <= sigmaLeft[9:0];
         pdmPulse <= slotHit;
      end
   end

   // Format is looked at every cycle, so a change takes effect at once
   wire isF1 = format == ppog_pkg::FMT_PWM_DIR;
   wire isF2 = format == ppog_pkg::FMT_UP_DOWN;
   wire isF3 = format == ppog_pkg::FMT_PDM_DIR;
   wire isF4 = format == ppog_pkg::FMT_DIR_PWM;
   wire dirLevel = dutyNeg & (magClip != 10'h000);
   wire upPulse = pwmPulse & ~dirLevel;
   wire downPulse = pwmPulse & dirLevel;
   wire selA = isF1 ? pwmPulse :
               isF2 ? upPulse :
               isF3 ? pdmPulse :
               isF4 ? dirLevel : 1'b0;
   wire selB = (isF1 | isF3) ? dirLevel :
               isF2 ? downPulse :
               isF4 ? pwmPulse : 1'b0;
   wire [2:0] next_fnVal = {enable & selB, enable & selA, ~enable};
   logic [2:0] fnVal;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fnVal <= 3'b001;
      end else begin
         fnVal <= next_fnVal;
      end
   end

   // One cell per pin: not-enable, first and second function output
   for (genvar i = 0; i < ppog_pkg::NUM_PINS; i++) begin : gPin
      wire drv = pinCfg[i].pinDriveDirection;
      wire val = fnVal[i] ^ pinCfg[i].flip;
      wire next_out = pinCfg[i].pinDrainOnly ? 1'b0 : val;
      wire next_oe = drv & (~pinCfg[i].pinDrainOnly | ~val);
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            pinCfg[i] <= '0;
            pinDrive.out[i] <= 1'b0;
            pinDrive.oe[i] <= 1'b0;
         end else begin
            if (wrStb & hitPin) begin
               pinCfg[i] <= pinNew[i*ppog_pkg::PIN_CFG_STRIDE +: 3];
            end
            pinDrive.out[i] <= drv & next_out;
            pinDrive.oe[i] <= next_oe;
         end
      end
   end

   // Drain-only check needs the pre-register value of pin 2
   wire val2 = gPin[2].val;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_NEN_LOW: assert property (
      enable && $past(enable) |-> !fnVal[ppog_pkg::PIN_NEN]
   ) else $error("not-enable high while enabled");

   AST_QUIET: assert property (
      !enable [*2] |-> fnVal == 3'b001
   ) else $error("pulses while disabled");

   AST_F1_DIR: assert property (
      $past(enable && isF1) |-> fnVal[2] == $past(dirLevel)
   ) else $error("format 1 direction wrong");

   AST_F4_SWAP: assert property (
      $past(enable && isF4) |->
         fnVal[1] == $past(dirLevel) && fnVal[2] == $past(pwmPulse)
   ) else $error("format 4 outputs wrong");

   AST_UPDOWN: assert property (
      $past(isF2) |-> !(fnVal[1] && fnVal[2])
   ) else $error("up and down both high");

   AST_CLIP: assert property (
      (dutyMag <= ppog_pkg::DUTY_FULL) and
      (magClip == ppog_pkg::DUTY_FULL |-> pwmPulse)
   ) else $error("duty exceeds full scale");

   AST_PDM_SLOT: assert property (
      $changed(pdmPulse) |-> $past(pdmTick)
   ) else $error("density output changed off slot");

   AST_PWM_RANGE: assert property (
      pwmHz >= ppog_pkg::PWM_MIN_HZ && pwmHz <= ppog_pkg::PWM_MAX_HZ
   ) else $error("pwm frequency out of range");

   AST_PDM_RANGE: assert property (
      $past(wrStb && hitPdm) |-> pdmHz <= ppog_pkg::PDM_MAX_HZ
   ) else $error("pdm frequency out of range");

   AST_FLIP: assert property (
      $past(pinCfg[1].pinDriveDirection && !pinCfg[1].pinDrainOnly) |->
         pinDrive.oe[1] && pinDrive.out[1] == $past(fnVal[1] ^ pinCfg[1].flip)
   ) else $error("push-pull value wrong");

   AST_DRAIN: assert property (
      $past(pinCfg[2].pinDrainOnly) |->
         !pinDrive.out[2] && (!pinDrive.oe[2] || !$past(val2))
   ) else $error("open drain drove high");

   AST_INPUT: assert property (
      $past(!pinCfg[0].pinDriveDirection) |-> !pinDrive.oe[0]
   ) else $error("input pin driven");

   COV_F1_RUN: cover property (enable && isF1 && pwmPulse ##1 !pwmPulse);
   COV_F2_DOWN: cover property (enable && isF2 && fnVal[2]);
   COV_F3_PULSE: cover property (enable && isF3 && pdmTick && slotHit);
   COV_FMT_CHANGE: cover property (enable && $changed(format));
endmodule : ppog_top
`default_nettype wire

// ==== verif/ppog_amp_model.sv ====
`default_nettype none
module ppog_amp_model (
   input wire ppog_pkg::ppog_pins_t pinDrive, // Pin drive from the block
   input wire logic [2:0] extLow, // Amplifier sinks a pin
   output logic [2:0] pinLevel // Resolved pin levels
);
   timeunit 1ns;
   timeprecision 1ps;
   // A released pin floats high on the pull-up unless the amplifier sinks it
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (pinDrive.oe[i]) begin
            pinLevel[i] = pinDrive.out[i];
         end else begin
            pinLevel[i] = !extLow[i];
         end
      end
   end
endmodule : ppog_amp_model
`default_nettype wire

// ==== verif/testbench.sv ====
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rstN = 1'b0;
   logic cyc, stb, we, ack;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [3:0] lane = 4'hf;
   logic [31:0] datW, datR, rd;
   logic [2:0] extLow, lvl;
   ppog_pkg::ppog_pins_t pinDrive;
   int failures = 0;
   int testsRun = 0;
   int cycles = 0;
   int cnt [3];

   ppog_top ppog_top_i (.clk(clk), .rst_n(rstN), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR),
      .wb_ack_o(ack), .pinSense(lvl), .pinDrive(pinDrive));
   ppog_amp_model ppog_amp_model_i (.pinDrive(pinDrive), .extLow(extLow), .pinLevel(lvl));

   initial begin
      forever #2.5 clk = ~clk;
   end

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", testsRun, failures);
      if (failures == 0 && testsRun > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize

   // Planned run is near 14k cycles; the margin covers slow acks
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         failures++;
         summarize();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // Counts drift a little with phase and rate rounding, so allow a band
   task automatic checkNear(input int c, input int e);
      check(32'((c > e - 12 && c < e + 12) ? e : c), 32'(e));
   endtask : checkNear

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      datW <= d;
      sel <= lane;
      do @(posedge clk); while (ack !== 1'b1);
      rd = datR;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : xfer

   task automatic measure();
      cnt = '{0, 0, 0};
      repeat (1024) begin
         @(negedge clk);
         for (int p = 0; p < 3; p++) cnt[p] += int'(lvl[p]);
      end
   endtask : measure

   function automatic logic [9:0] expMag(input logic signed [15:0] c, input logic [15:0] s);
      int v;
      v = c;
      v = (v < 0) ? -v : v;
      if (c == 0) return 10'h000;
      if (s == 0) return 10'h200;
      v = v * 512 / int'(s);
      return (v > 512) ? 10'h200 : 10'(v);
   endfunction : expMag

   // High cycles expected per pin over a 1024-cycle window (two PWM periods)
   function automatic int expCnt(input int f, input logic neg, input int mag, input int pin);
      case (f)
         1, 3: return (pin == 1) ? mag * 2 : (neg ? 1024 : 0);
         2: return ((pin == 1) != neg) ? mag * 2 : 0;
         4: return (pin == 2) ? mag * 2 : (neg ? 1024 : 0);
         default: return 0;
      endcase
   endfunction : expCnt

   initial begin
      logic signed [15:0] c;
      logic [15:0] s;
      int m;
      logic [31:0] d;
      {cyc, stb, we, adr, sel, datW, extLow} = '0;
      void'($urandom(32'h2ed5671b));
      repeat (16) @(posedge clk);
      rstN <= 1'b1;
      @(negedge clk);
      check(32'(pinDrive), 32'h0);
      xfer(1'b0, ppog_pkg::OFS_CTRL, 32'h0);
      check(rd, 32'h10);
      xfer(1'b0, 8'hfc, 32'h0);
      check(rd, 32'h0);
      // Lane 1 only: the other bytes of the command keep their old value
      d = $urandom;
      lane <= 4'h2;
      xfer(1'b1, ppog_pkg::OFS_COMMAND, d);
      lane <= 4'hf;
      xfer(1'b0, ppog_pkg::OFS_COMMAND, 32'h0);
      check(rd, {16'h0, d[15:8], 8'h00});
      for (int i = 0; i < 4; i++) begin
         adr <= (i < 2) ? ppog_pkg::OFS_PWM_HZ : ppog_pkg::OFS_PDM_HZ;
         @(posedge clk);
         xfer(1'b1, adr, i[0] ? 32'hffffffff : 32'h0);
         xfer(1'b0, adr, 32'h0);
         check(rd, i == 0 ? ppog_pkg::PWM_MIN_HZ : i == 1 ? ppog_pkg::PWM_MAX_HZ :
            i == 2 ? ppog_pkg::PDM_MIN_HZ : ppog_pkg::PDM_MAX_HZ);
      end
      for (int i = 0; i < 12; i++) begin
         c = 16'($urandom_range(8000)) - 16'd4000;
         s = 16'($urandom_range(4000, 1));
         if (i == 0) s = 16'h0000;
         if (i == 1) c = 16'h8000;
         if (i == 2) s = 16'(c);
         xfer(1'b1, ppog_pkg::OFS_COMMAND, 32'(c));
         xfer(1'b1, ppog_pkg::OFS_SCALE, 32'(s));
         repeat (24) @(posedge clk);
         xfer(1'b0, ppog_pkg::OFS_STATUS, 32'h0);
         check(32'(rd[25:16]), 32'(expMag(c, s)));
         check(32'(rd[4]), 32'(c[15]));
      end
      xfer(1'b1, ppog_pkg::OFS_PIN_CFG, 32'h111);
      xfer(1'b1, ppog_pkg::OFS_PWM_HZ, ppog_pkg::PWM_MAX_HZ);
      xfer(1'b1, ppog_pkg::OFS_PDM_HZ, 32'd100000000);
      xfer(1'b1, ppog_pkg::OFS_SCALE, 32'd512);
      xfer(1'b1, ppog_pkg::OFS_COMMAND, 32'd300);
      xfer(1'b1, ppog_pkg::OFS_CTRL, 32'h40);
      repeat (16) @(posedge clk);
      measure();
      check(32'(cnt[0] + cnt[1] * 2048 + cnt[2] * 4096), 32'd1024);
      // Format 5 is out of range and must leave both function outputs low
      for (int f = 1; f < 6; f++) begin
         for (int n = 0; n < 2; n++) begin
            m = $urandom_range(400, 100);
            xfer(1'b1, ppog_pkg::OFS_COMMAND, n ? 32'(-m) : 32'(m));
            xfer(1'b1, ppog_pkg::OFS_CTRL, (32'(f) << ppog_pkg::CTRL_FMT_LSB) | 32'h1);
            repeat (24) @(posedge clk);
            measure();
            check(32'(cnt[0]), 32'd0);
            checkNear(cnt[1], expCnt(f, n[0], m, 1));
            checkNear(cnt[2], expCnt(f, n[0], m, 2));
         end
      end
      // Pin 0 flipped but undriven and sunk outside, so a driven high shows;
      // pin 1 flipped push-pull, pin 2 drain-only
      xfer(1'b1, ppog_pkg::OFS_PIN_CFG, 32'h354);
      extLow <= 3'b001;
      xfer(1'b1, ppog_pkg::OFS_CTRL, 32'h11);
      for (int n = 0; n < 2; n++) begin
         xfer(1'b1, ppog_pkg::OFS_COMMAND, n ? 32'hfffffe00 : 32'h200);
         repeat (24) @(posedge clk);
         measure();
         check(32'(cnt[0]), 32'd0);
         check(32'(cnt[1]), 32'd0);
         check(32'(cnt[2]), n ? 32'd1024 : 32'd0);
      end
      xfer(1'b0, ppog_pkg::OFS_STATUS, 32'h0);
      check(32'(rd[2:0]), 32'h4);
      extLow <= 3'b100;
      repeat (4) @(posedge clk);
      xfer(1'b0, ppog_pkg::OFS_STATUS, 32'h0);
      check(32'(rd[2:0]), 32'h1);
      // A reset in mid-run must return every pin to an undriven input
      rstN <= 1'b0;
      repeat (4) @(posedge clk);
      check(32'(pinDrive), 32'h0);
      rstN <= 1'b1;
      xfer(1'b0, ppog_pkg::OFS_CTRL, 32'h0);
      check(rd, 32'h10);
      summarize();
   end
endmodule : testbench
`default_nettype wire
